// *** epc_core.sv ***
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - prescaler divides timer clock by any ratio from 1 to 65536.
// - down counting reloads the period value on underflow.
// - up counting rolls over to zero after passing the period value.
// - center mode counts 0..period-1, overflow, period..1, underflow, then 0.
// - overflow or underflow issues an update event usable for interrupt or DMA.
// - update event copies prescaler, period, compare and mode into shadows.
// - new prescaler ratio applies only at an update event.
// - repetition counter issues update once every N periods, N up to 65536; in center mode once every N half periods.
// - software sets direction; center mode reverses it at overflow and underflow.
// - quadrature mode counts active encoder edges, direction from phase.
// - x1 counts A falling while direction 0, A rising while direction 1.
// - x2 and x4 resolutions selectable by the slave mode field.
// - slave mode field may be preloaded and switched at update events.
// - clock plus direction counts input two, direction from input one level.
// - directional clock counts up on one line and down on the other.
// - index resets counter in quadrature, clock-direction and directional clock modes.
// - two-bit position field selects A/B levels qualifying the index.
// - index clears counter counting up, loads period value counting down.
// - direction field restricts index; 01 acts only while counting up.
// - first-index-only bit acts on first index after enable, ignores later ones.
// - period, compare and mode copy continuously or at update per preload setting; prescaler and repetition only at update.
module epc_core (
  input  wire logic        MCLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        TIMER_INPUT_ONE_IN,
  input  wire logic        TIMER_INPUT_TWO_IN,
  input  wire logic        EXTERNAL_TRIGGER_INPUT_IN,
  output logic             UPDATE_EVENT_OUT,
  output logic             DIR_OUT,
  output logic             COMPARE_OUT
);

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        en;
    logic        sw_dir;
    logic        center;
    logic        arpe;
    logic        ccpe;
    logic        smpe;
    logic [2:0]  smode_pre;
    logic [2:0]  smode_act;
    logic        idx_en;
    logic [1:0]  index_direction_select;
    logic        first_index_only;
    logic [1:0]  index_position_select;
    logic [15:0] psc_pre;
    logic [15:0] psc_act;
    logic [15:0] psc_cnt;
    logic [15:0] period_pre;
    logic [15:0] period_act;
    logic [15:0] rep_pre;
    logic [15:0] rep_act;
    logic [15:0] rep_cnt;
    logic [15:0] cmp_pre;
    logic [15:0] cmp_act;
    logic        ocm_pre;
    logic        ocm_act;
    logic [15:0] cnt;
    logic        dir;
    logic        uev;
    logic        uif;
    logic        idx_flag;
    logic        idx_done;
    logic        oc;
    logic [2:0]  a_sync;
    logic [2:0]  b_sync;
    logic [1:0]  z_sync;
    logic        z_qual;
  } epc_state_t;

  epc_state_t r_q;
  epc_state_t r_d;

  // returns {wrapped, next} for one edge-aligned count step
  function automatic logic [16:0] epc_step(input logic [15:0] c, input logic [15:0] p,
                                           input logic up);
    logic [16:0] res;
    res = 17'h0_0000;
    if (up) begin
      if (c >= p) res = 17'h1_0000;
      else res = {1'b0, c + 16'h0001};
    end else begin
      if (c == 16'h0000) res = {1'b1, p};
      else res = {1'b0, c - 16'h0001};
    end
    return res;
  endfunction

  function automatic logic epc_edge(input logic [2:0] s, input logic rising);
    return rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
  endfunction

  always_comb begin
    logic        tick;
    logic        down;
    logic        ovf;
    logic        udf;
    logic        uev;
    logic        a_chg;
    logic        b_chg;
    logic        enc_mode;
    logic        idx_hit;
    logic        acc;
    logic [16:0] st;
    logic [15:0] nxt;
    tick     = 1'b0;
    ovf      = 1'b0;
    udf      = 1'b0;
    uev      = 1'b0;
    idx_hit  = 1'b0;
    st       = 17'h0_0000;
    nxt      = 16'h0000;
    r_d      = r_q;
    acc      = PSEL_IN & PENABLE_IN;
    r_d.a_sync = {r_q.a_sync[1:0], TIMER_INPUT_ONE_IN};
    r_d.b_sync = {r_q.b_sync[1:0], TIMER_INPUT_TWO_IN};
    r_d.z_sync = {r_q.z_sync[0], EXTERNAL_TRIGGER_INPUT_IN};
    a_chg    = r_q.a_sync[1] ^ r_q.a_sync[2];
    b_chg    = r_q.b_sync[1] ^ r_q.b_sync[2];
    enc_mode = (r_q.smode_act != epc_pkg::SM_INTERNAL);
    down     = r_q.dir;

    case (r_q.smode_act)
      epc_pkg::SM_INTERNAL: begin
        if (!r_q.center) down = r_q.sw_dir;
        if (r_q.en) begin
          if (r_q.psc_cnt >= r_q.psc_act) begin
            r_d.psc_cnt = 16'h0000;
            tick = 1'b1;
          end else begin
            r_d.psc_cnt = r_q.psc_cnt + 16'h0001;
          end
        end
      end
      epc_pkg::SM_X1: begin
        if (a_chg) begin
          down = ~(r_q.a_sync[1] ^ r_q.b_sync[1]);
          tick = down ? epc_edge(r_q.a_sync, 1'b1)
                      : epc_edge(r_q.a_sync, 1'b0);
        end
      end
      epc_pkg::SM_X2: begin
        if (a_chg) begin
          down = ~(r_q.a_sync[1] ^ r_q.b_sync[1]);
          tick = 1'b1;
        end
      end
      epc_pkg::SM_X4: begin
        if (a_chg) begin
          down = ~(r_q.a_sync[1] ^ r_q.b_sync[1]);
          tick = 1'b1;
        end else if (b_chg) begin
          down = r_q.a_sync[1] ^ r_q.b_sync[1];
          tick = 1'b1;
        end
      end
      epc_pkg::SM_CLKDIR: begin
        down = r_q.a_sync[1];
        tick = epc_edge(r_q.b_sync, 1'b1);
      end
      epc_pkg::SM_DIRCLK: begin
        // simultaneous pulses on both lines cancel out
        if (epc_edge(r_q.a_sync, 1'b1) != epc_edge(r_q.b_sync, 1'b1)) begin
          tick = 1'b1;
          down = epc_edge(r_q.b_sync, 1'b1);
        end
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    if (!r_q.en) tick = 1'b0;
    r_d.dir = down;

    if (tick) begin
      if (r_q.center && !enc_mode) begin
        if (!r_q.dir) begin
          nxt = r_q.cnt + 16'h0001;
          if (nxt >= r_q.period_act) begin
            ovf       = 1'b1;
            r_d.cnt   = r_q.period_act;
            r_d.dir   = 1'b1;
          end else begin
            r_d.cnt   = nxt;
          end
        end else begin
          if (r_q.cnt <= 16'h0001) begin
            udf       = 1'b1;
            r_d.cnt   = 16'h0000;
            r_d.dir   = 1'b0;
          end else begin
            r_d.cnt   = r_q.cnt - 16'h0001;
          end
        end
      end else begin
        st      = epc_step(r_q.cnt, r_q.period_act, ~down);
        r_d.cnt = st[15:0];
        ovf     = st[16] & ~down;
        udf     = st[16] & down;
      end
    end

    // index qualified by channel levels, acted on at its rising edge
    r_d.z_qual = r_q.z_sync[1] & ({r_q.b_sync[1], r_q.a_sync[1]} == r_q.index_position_select);
    if (r_d.z_qual && !r_q.z_qual && r_q.idx_en && enc_mode && r_q.en) begin
      idx_hit = 1'b1;
      if (r_q.index_direction_select == epc_pkg::INDEX_DIRECTION_SELECT_UP_ONLY && down) idx_hit = 1'b0;
      if (r_q.index_direction_select == epc_pkg::INDEX_DIRECTION_SELECT_DOWN_ONLY && !down) idx_hit = 1'b0;
      if (r_q.first_index_only && r_q.idx_done) idx_hit = 1'b0;
    end
    if (idx_hit) begin
      r_d.cnt      = down ? r_q.period_act : 16'h0000;
      r_d.idx_done = 1'b1;
    end

    // repetition counter thins update events
    if (ovf || udf) begin
      if (r_q.rep_cnt == 16'h0000) begin
        uev = 1'b1;
        r_d.rep_cnt = r_q.rep_act;
      end else begin
        r_d.rep_cnt = r_q.rep_cnt - 16'h0001;
      end
    end
    r_d.uev = uev;

    if (uev) begin
      r_d.psc_act = r_q.psc_pre;
      r_d.rep_act = r_q.rep_pre;
      r_d.psc_cnt = 16'h0000;
    end
    if (uev || !r_q.arpe) r_d.period_act = r_q.period_pre;
    if (uev || !r_q.ccpe) begin
      r_d.cmp_act = r_q.cmp_pre;
      r_d.ocm_act = r_q.ocm_pre;
    end
    if (uev || !r_q.smpe) r_d.smode_act = r_q.smode_pre;

    r_d.oc = (r_q.cnt < r_q.cmp_act) ^ r_q.ocm_act;

    // two-cycle access: pready rises one cycle into the access phase
    r_d.pready  = acc & ~r_q.pready;
    r_d.pslverr = 1'b0;
    if (acc && !r_q.pready) begin
      r_d.prdata = epc_pkg::RST_ZERO32;
      case (PADDR_IN)
        epc_pkg::ADDR_CTRL:   r_d.prdata[6:0] = {r_q.ocm_pre, r_q.smpe, r_q.ccpe, r_q.arpe,
                                                 r_q.center, r_q.sw_dir, r_q.en};
        epc_pkg::ADDR_SMODE:  r_d.prdata[2:0] = r_q.smode_pre;
        epc_pkg::ADDR_ENC:    r_d.prdata[5:0] = {r_q.index_position_select, r_q.first_index_only, r_q.index_direction_select, r_q.idx_en};
        epc_pkg::ADDR_PSC:    r_d.prdata[15:0] = r_q.psc_pre;
        epc_pkg::ADDR_PERIOD: r_d.prdata[15:0] = r_q.period_pre;
        epc_pkg::ADDR_REP:    r_d.prdata[15:0] = r_q.rep_pre;
        epc_pkg::ADDR_CNT:    r_d.prdata[15:0] = r_q.cnt;
        epc_pkg::ADDR_STATUS: r_d.prdata[2:0] = {r_q.idx_flag, r_q.dir, r_q.uif};
        epc_pkg::ADDR_CMP:    r_d.prdata[15:0] = r_q.cmp_pre;
        default:              r_d.pslverr = 1'b1;
      endcase
    end

    if (acc && r_q.pready && PWRITE_IN) begin
      case (PADDR_IN)
        epc_pkg::ADDR_CTRL: begin
          r_d.en      = PWDATA_IN[epc_pkg::CTRL_EN];
          r_d.sw_dir  = PWDATA_IN[epc_pkg::CTRL_DIR];
          r_d.center  = PWDATA_IN[epc_pkg::CTRL_CENTER];
          r_d.arpe    = PWDATA_IN[epc_pkg::CTRL_ARPE];
          r_d.ccpe    = PWDATA_IN[epc_pkg::CTRL_CCPE];
          r_d.smpe    = PWDATA_IN[epc_pkg::CTRL_SMPE];
          r_d.ocm_pre = PWDATA_IN[epc_pkg::CTRL_OCM];
          // re-arming the first-index latch happens on each fresh enable
          if (PWDATA_IN[epc_pkg::CTRL_EN] && !r_q.en) r_d.idx_done = 1'b0;
        end
        epc_pkg::ADDR_SMODE:  r_d.smode_pre = PWDATA_IN[2:0];
        epc_pkg::ADDR_ENC: begin
          r_d.idx_en = PWDATA_IN[epc_pkg::ENC_IDX_EN];
          r_d.index_direction_select   = PWDATA_IN[epc_pkg::ENC_INDEX_DIRECTION_SELECT_LSB +: 2];
          r_d.first_index_only   = PWDATA_IN[epc_pkg::ENC_FIRST_INDEX_ONLY];
          r_d.index_position_select   = PWDATA_IN[epc_pkg::ENC_INDEX_POSITION_SELECT_LSB +: 2];
        end
        epc_pkg::ADDR_PSC:    r_d.psc_pre = PWDATA_IN[15:0];
        epc_pkg::ADDR_PERIOD: r_d.period_pre = PWDATA_IN[15:0];
        epc_pkg::ADDR_REP:    r_d.rep_pre = PWDATA_IN[15:0];
        epc_pkg::ADDR_CNT:    r_d.cnt = PWDATA_IN[15:0];
        epc_pkg::ADDR_STATUS: begin
          if (PWDATA_IN[epc_pkg::ST_UIF])  r_d.uif = 1'b0;
          if (PWDATA_IN[epc_pkg::ST_IDXF]) r_d.idx_flag = 1'b0;
        end
        epc_pkg::ADDR_CMP:    r_d.cmp_pre = PWDATA_IN[15:0];
        default:              r_d.cnt = r_d.cnt;
      endcase
    end

    // hardware sets beat a software clear in the same cycle
    if (uev) r_d.uif = 1'b1;
    if (idx_hit) r_d.idx_flag = 1'b1;
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      r_q            <= '0;
      r_q.period_pre <= epc_pkg::RST_PERIOD;
      r_q.period_act <= epc_pkg::RST_PERIOD;
      r_q.psc_pre    <= epc_pkg::RST_ZERO16;
      r_q.cmp_pre    <= epc_pkg::RST_ZERO16;
      r_q.prdata     <= epc_pkg::RST_ZERO32;
    end else begin
      r_q <= r_d;
    end
  end

  assign PRDATA_OUT       = r_q.prdata;
  assign PREADY_OUT       = r_q.pready;
  assign PSLVERR_OUT      = r_q.pslverr;
  assign UPDATE_EVENT_OUT = r_q.uev;
  assign DIR_OUT          = r_q.dir;
  assign COMPARE_OUT      = r_q.oc;

endmodule

// *** epc_core_monitor.sv ***
`timescale 1ns/1ps
module epc_core_monitor (
  input wire logic        MCLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        UPDATE_EVENT_OUT,
  input wire logic        DIR_OUT,
  input wire logic        COMPARE_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);
  AST_UEV_PULSE: assert property (UPDATE_EVENT_OUT |=> !UPDATE_EVENT_OUT)
    else $error("update event longer than one cycle");
  // exactly one wait state, so software timing is fixed
  AST_APB_WAIT: assert property (PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT)
    else $error("ready not after one wait state");
  AST_APB_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  AST_ERR_MAP: assert property (PREADY_OUT && PADDR_IN[1:0] == 2'h0
    |-> PSLVERR_OUT == (PADDR_IN > epc_pkg::ADDR_CMP))
    else $error("error flag wrong for address");
  AST_ERR_DATA: assert property (PSLVERR_OUT
    |-> PREADY_OUT && (PWRITE_IN || PRDATA_OUT == 32'h0000_0000))
    else $error("refused access without ready or with data");
  AST_RDATA_HOLD: assert property (!(PSEL_IN && PENABLE_IN) && !PREADY_OUT |=> $stable(PRDATA_OUT))
    else $error("read data moved outside an access");
  AST_RESET_QUIET: assert property ($rose(RSTN_IN)
    |-> !UPDATE_EVENT_OUT && !DIR_OUT && !COMPARE_OUT && !PREADY_OUT)
    else $error("outputs not quiet after reset");
  AST_DIR_READ: assert property (
    PREADY_OUT && !PWRITE_IN && PADDR_IN == epc_pkg::ADDR_STATUS && $stable(DIR_OUT)
    && $past(DIR_OUT, 2) == DIR_OUT |-> PRDATA_OUT[epc_pkg::ST_DIR] == DIR_OUT)
    else $error("status direction differs from direction output");
endmodule
bind epc_core epc_core_monitor mon_u (.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .UPDATE_EVENT_OUT(UPDATE_EVENT_OUT), .DIR_OUT(DIR_OUT), .COMPARE_OUT(COMPARE_OUT));

// *** epc_enc_model.sv ***
`timescale 1ns/1ps
module epc_enc_model (
  input  wire logic clk,
  output logic      chan_a,
  output logic      chan_b,
  output logic      index
);
  // mode: 0 quadrature, 1 clock plus direction, 2 directional clock
  logic [1:0] mode = 2'h0;
  logic [3:0] pos  = 4'h0;
  initial begin
    chan_a = 1'b0;
    chan_b = 1'b0;
    index  = 1'b0;
  end
  // lines are always driven, so they never float between moves
  task automatic step(input logic dn, input int gap);
    @(posedge clk);
    if (mode == 2'h0) begin
      pos = dn ? pos - 4'h1 : pos + 4'h1;
      chan_a <= pos[1] ^ pos[0];
      chan_b <= pos[1];
      index  <= (pos == 4'h2);
    end else begin
      if (mode == 2'h1) chan_a <= dn;
      repeat (gap) @(posedge clk);
      if (mode == 2'h1 || dn) chan_b <= 1'b1;
      else chan_a <= 1'b1;
      repeat (gap) @(posedge clk);
      if (mode == 2'h1 || dn) chan_b <= 1'b0;
      else chan_a <= 1'b0;
    end
    // extra edges cover the two-stage synchroniser in the core
    repeat (gap + 2) @(posedge clk);
  endtask
endmodule

// *** epc_pkg.sv ***
package epc_pkg;
  localparam int          DW             = 16;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_SMODE     = 8'h04;
  localparam logic [7:0]  ADDR_ENC       = 8'h08;
  localparam logic [7:0]  ADDR_PSC       = 8'h0C;
  localparam logic [7:0]  ADDR_PERIOD    = 8'h10;
  localparam logic [7:0]  ADDR_REP       = 8'h14;
  localparam logic [7:0]  ADDR_CNT       = 8'h18;
  localparam logic [7:0]  ADDR_STATUS    = 8'h1C;
  localparam logic [7:0]  ADDR_CMP       = 8'h20;
  // control register fields
  localparam int          CTRL_EN        = 0;
  localparam int          CTRL_DIR       = 1;
  localparam int          CTRL_CENTER    = 2;
  localparam int          CTRL_ARPE      = 3;
  localparam int          CTRL_CCPE      = 4;
  localparam int          CTRL_SMPE      = 5;
  localparam int          CTRL_OCM       = 6;
  // encoder control register fields
  localparam int          ENC_IDX_EN     = 0;
  localparam int          ENC_INDEX_DIRECTION_SELECT_LSB   = 1;
  localparam int          ENC_FIRST_INDEX_ONLY       = 3;
  localparam int          ENC_INDEX_POSITION_SELECT_LSB   = 4;
  // status register fields
  localparam int          ST_UIF         = 0;
  localparam int          ST_DIR         = 1;
  localparam int          ST_IDXF        = 2;
  // slave mode encodings
  localparam logic [2:0]  SM_INTERNAL    = 3'h0;
  localparam logic [2:0]  SM_X1          = 3'h1;
  localparam logic [2:0]  SM_X2          = 3'h2;
  localparam logic [2:0]  SM_X4          = 3'h3;
  localparam logic [2:0]  SM_CLKDIR      = 3'h4;
  localparam logic [2:0]  SM_DIRCLK      = 3'h5;
  // index direction encodings
  localparam logic [1:0]  INDEX_DIRECTION_SELECT_UP_ONLY   = 2'h1;
  localparam logic [1:0]  INDEX_DIRECTION_SELECT_DOWN_ONLY = 2'h2;
  // reset values
  localparam logic [15:0] RST_PERIOD     = 16'hFFFF;
  localparam logic [15:0] RST_ZERO16     = 16'h0000;
  localparam logic [31:0] RST_ZERO32     = 32'h0000_0000;
endpackage

// *** test_encoder_period_counter.sv ***
`timescale 1ns/1ps
module test_encoder_period_counter;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ch_a;
  logic        ch_b;
  logic        idx;
  logic        uev;
  logic        dir;
  logic        cmp;
  logic [31:0] rd;
  logic        err;
  logic [15:0] psc;
  logic [15:0] per;
  logic [15:0] rep;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  int          last = 0;
  int          dt;
  int          i;
  int          j;
  int          m;
  logic [7:0]  enc_tab [5] = '{8'h01, 8'h31, 8'h33, 8'h35, 8'h39};
  logic [7:0]  idx_exp [5] = '{8'h10, 8'hFD, 8'hFE, 8'hFD, 8'hFE};
  epc_core dut_u (.MCLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TIMER_INPUT_ONE_IN(ch_a),
    .TIMER_INPUT_TWO_IN(ch_b), .EXTERNAL_TRIGGER_INPUT_IN(idx), .UPDATE_EVENT_OUT(uev),
    .DIR_OUT(dir), .COMPARE_OUT(cmp));
  epc_enc_model enc_u (.clk(clk), .chan_a(ch_a), .chan_b(ch_b), .index(idx));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic wrap_up();
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // pready, read data and error are taken at the rising edge that completes the transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask
  task automatic wait_uev(output int t);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (uev !== 1'b1 && n < 8000);
    if (uev !== 1'b1) begin
      failures++;
      wrap_up();
    end
    t = cyc - last;
    last = cyc;
  endtask
  task automatic setup(input logic [2:0] sm, input logic [15:0] p, r, q, c,
                       input logic [7:0] enc, ctl);
    apb(1'b1, epc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, epc_pkg::ADDR_SMODE, {29'h0, sm});
    apb(1'b1, epc_pkg::ADDR_PSC, {16'h0, p});
    apb(1'b1, epc_pkg::ADDR_PERIOD, {16'h0, r});
    apb(1'b1, epc_pkg::ADDR_REP, {16'h0, q});
    apb(1'b1, epc_pkg::ADDR_CNT, {16'h0, c});
    apb(1'b1, epc_pkg::ADDR_ENC, {24'h0, enc});
    apb(1'b1, epc_pkg::ADDR_CTRL, {24'h0, ctl});
  endtask
  // cycles between updates: center mode spends per counts each way
  function automatic int exp_len(int p, int r, int q, int md);
    return (p + 1) * (md == 2 ? r : r + 1) * (q + 1);
  endfunction
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(31));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rdc("ctrl reset", epc_pkg::ADDR_CTRL, 32'h0);
    rdc("period reset", epc_pkg::ADDR_PERIOD, 32'h0000_FFFF);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    for (i = 0; i < 8; i++) begin
      psc = (i < 2) ? 16'h0 : 16'($urandom % 4);
      per = (i < 2) ? 16'h1 : 16'(2 + $urandom % 4);
      rep = (i == 1) ? 16'h00FF : 16'($urandom % 3);
      m = (i < 2) ? 0 : int'($urandom % 3);
      setup(epc_pkg::SM_INTERNAL, psc, per, rep, 16'h0, 8'h0,
            (m == 2) ? 8'h05 : ((m == 1) ? 8'h03 : 8'h01));
      repeat (3) wait_uev(dt);
      chk("period", dt, exp_len(psc, per, rep, m));
      if (m < 2) chk("direction", {31'h0, dir}, m);
    end
    setup(epc_pkg::SM_INTERNAL, 16'h3, 16'h3, 16'h0, 16'h0, 8'h0, 8'h01);
    repeat (2) wait_uev(dt);
    apb(1'b1, epc_pkg::ADDR_PSC, 32'h1);
    wait_uev(dt);
    chk("ratio held", dt, exp_len(3, 3, 0, 0));
    wait_uev(dt);
    chk("ratio new", dt, exp_len(1, 3, 0, 0));
    // compare shadow: live while preload is off, held while on, copied at update
    setup(epc_pkg::SM_INTERNAL, 16'h0, 16'h00FF, 16'h0, 16'h0005, 8'h0, 8'h00);
    apb(1'b1, epc_pkg::ADDR_CMP, 32'h8);
    repeat (4) @(negedge clk);
    chk("compare live", {31'h0, cmp}, 32'h1);
    apb(1'b1, epc_pkg::ADDR_CTRL, 32'h50);
    apb(1'b1, epc_pkg::ADDR_CMP, 32'h80);
    repeat (4) @(negedge clk);
    chk("compare held", {31'h0, cmp}, 32'h1);
    apb(1'b1, epc_pkg::ADDR_CTRL, 32'h51);
    wait_uev(dt);
    repeat (2) @(negedge clk);
    chk("compare shadow", {31'h0, cmp}, 32'h0);
    for (i = 1; i < 4; i++) begin
      setup(3'(i), 16'h0, 16'h00FF, 16'h0, 16'h0, 8'h0, 8'h01);
      repeat (8) enc_u.step(1'b0, 2 + $urandom % 4);
      rdc("quad up", epc_pkg::ADDR_CNT, 32'h2 << (i - 1));
      repeat (8) enc_u.step(1'b1, 2 + $urandom % 4);
      rdc("quad down", epc_pkg::ADDR_CNT, 32'h0);
      apb(1'b0, epc_pkg::ADDR_STATUS, 32'h0);
      chk("dir status", {31'h0, rd[epc_pkg::ST_DIR]}, 32'h1);
    end
    for (i = 0; i < 5; i++) begin
      setup(epc_pkg::SM_X4, 16'h0, 16'h00FF, 16'h0, 16'h0010, enc_tab[i], 8'h01);
      for (j = 0; j < 8; j++) enc_u.step(j > 3, 2 + $urandom % 4);
      rdc("index", epc_pkg::ADDR_CNT, {24'h0, idx_exp[i]});
    end
    // preloaded x1 must not apply before an update, so x4 keeps counting
    setup(epc_pkg::SM_X4, 16'h0, 16'h00FF, 16'h0, 16'h0, 8'h0, 8'h21);
    apb(1'b1, epc_pkg::ADDR_SMODE, {29'h0, epc_pkg::SM_X1});
    repeat (4) enc_u.step(1'b0, 2 + $urandom % 4);
    rdc("mode preload", epc_pkg::ADDR_CNT, 32'h4);
    for (i = 1; i < 3; i++) begin
      enc_u.mode = 2'(i);
      setup(3'(i + 3), 16'h0, 16'h00FF, 16'h0, 16'h0, 8'h0, 8'h01);
      for (j = 0; j < 5; j++) enc_u.step(j == 2, 2 + $urandom % 4);
      rdc("pulse count", epc_pkg::ADDR_CNT, 32'h3);
    end
    wrap_up();
  end
endmodule
